// [logic/sfc_pkg.sv]
// Package: shared constants, types and carriers of the front-end config bank
`default_nettype none
package sfc_pkg;

  // ==========================================================================
  // Register byte addresses
  localparam logic [31:0] SFC_ADDR_BRIDGE = 32'h40000034;
  localparam logic [31:0] SFC_ADDR_PGAIN = 32'h40000035;
  localparam logic [31:0] SFC_ADDR_TGAIN = 32'h40000036;
  localparam logic [31:0] SFC_ADDR_TSRC = 32'h40000037;
  localparam logic [31:0] SFC_ADDR_TOUT = 32'h4000003A;

  // ==========================================================================
  // Implemented bits of each register; all other bits are unused
  localparam logic [7:0] SFC_MASK_BRIDGE = 8'h07;
  localparam logic [7:0] SFC_MASK_PGAIN = 8'h9F;
  localparam logic [7:0] SFC_MASK_TGAIN = 8'h83;
  localparam logic [7:0] SFC_MASK_TSRC = 8'h7F;
  localparam logic [7:0] SFC_MASK_TOUT = 8'h01;

  // ==========================================================================
  // Values after reset
  localparam logic [7:0] SFC_RST_BRIDGE = 8'h00;
  localparam logic [7:0] SFC_RST_PGAIN = 8'h00;
  localparam logic [7:0] SFC_RST_TGAIN = 8'h00;
  localparam logic [7:0] SFC_RST_TSRC = 8'h40;
  localparam logic [7:0] SFC_RST_TOUT = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int SFC_POS_BRIDGE_ON = 0;
  localparam int SFC_POS_LEVEL_LO = 1;
  localparam int SFC_POS_FLIP = 7;
  localparam int SFC_POS_TSRC_LO = 0;
  localparam int SFC_POS_CURR_LO = 4;
  localparam int SFC_POS_SINGLE_ENDED = 0;

  // ==========================================================================
  // Field codes
  localparam logic [3:0] SFC_TSRC_EXT_PINS = 4'h0;
  localparam logic [3:0] SFC_TSRC_INTERNAL = 4'h3;

  // Cycles from a register write to the decoded analog controls
  localparam int SFC_CTRL_LATENCY = 2;

  // ==========================================================================
  // Decoded modes
  typedef enum logic [1:0] {
    SFC_LEVEL_2V5,
    SFC_LEVEL_2V0,
    SFC_LEVEL_1V25
  } sfc_level_t;

  typedef enum logic [1:0] {
    SFC_SRC_EXT_PINS,
    SFC_SRC_INTERNAL,
    SFC_SRC_RESERVED
  } sfc_tsrc_t;

  typedef enum logic [2:0] {
    SFC_CURR_25UA,
    SFC_CURR_50UA,
    SFC_CURR_100UA,
    SFC_CURR_500UA,
    SFC_CURR_OFF
  } sfc_curr_t;

  // ==========================================================================
  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [7:0] wdata;
  } sfc_req_t;

  // Raw register contents
  typedef struct packed {
    logic [7:0] bridge;
    logic [7:0] pgain;
    logic [7:0] tgain;
    logic [7:0] tsrc;
    logic [7:0] tout;
  } sfc_regs_t;

  // Decoded analog control lines
  typedef struct packed {
    logic bridge_supply_on;
    sfc_level_t bridge_level_sel;
    logic [4:0] pressure_gain;
    logic pressure_polarity_flip;
    logic [1:0] temp_gain;
    logic temp_polarity_flip;
    sfc_tsrc_t temp_source;
    sfc_curr_t temp_excite_current_sel;
    logic temp_single_ended_sel;
  } sfc_afe_t;

endpackage
`default_nettype wire

// [logic/sfc_afe_decode.sv]
// Decoder from raw register bytes to registered analog control lines
`timescale 1ns/1ps
`default_nettype none
module sfc_afe_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Raw register contents
  input wire sfc_pkg::sfc_regs_t regs,
  // Decoded controls
  output var sfc_pkg::sfc_afe_t afe
);
  import sfc_pkg::*;

  // ==========================================================================
  // Decode functions
  function automatic sfc_level_t level_of(input logic [1:0] code);
    case (code)
      2'h0: level_of = SFC_LEVEL_2V5;
      2'h1: level_of = SFC_LEVEL_2V0;
      default: level_of = SFC_LEVEL_1V25;
    endcase
  endfunction

  function automatic sfc_tsrc_t source_of(input logic [3:0] code);
    if (code == SFC_TSRC_EXT_PINS) begin
      source_of = SFC_SRC_EXT_PINS;
    end else if (code == SFC_TSRC_INTERNAL) begin
      source_of = SFC_SRC_INTERNAL;
    end else begin
      source_of = SFC_SRC_RESERVED;
    end
  endfunction

  function automatic sfc_curr_t current_of(input logic [2:0] code);
    case (code)
      3'h0: current_of = SFC_CURR_25UA;
      3'h1: current_of = SFC_CURR_50UA;
      3'h2: current_of = SFC_CURR_100UA;
      3'h3: current_of = SFC_CURR_500UA;
      default: current_of = SFC_CURR_OFF;
    endcase
  endfunction

  // ==========================================================================
  // Combinational decode
  sfc_afe_t next_afe;
  assign next_afe.bridge_supply_on = regs.bridge[SFC_POS_BRIDGE_ON];
  assign next_afe.bridge_level_sel =
    level_of(regs.bridge[SFC_POS_LEVEL_LO +: 2]);
  assign next_afe.pressure_gain = regs.pgain[4:0];
  assign next_afe.pressure_polarity_flip = regs.pgain[SFC_POS_FLIP];
  assign next_afe.temp_gain = regs.tgain[1:0];
  assign next_afe.temp_polarity_flip = regs.tgain[SFC_POS_FLIP];
  assign next_afe.temp_source =
    source_of(regs.tsrc[SFC_POS_TSRC_LO +: 4]);
  assign next_afe.temp_excite_current_sel =
    current_of(regs.tsrc[SFC_POS_CURR_LO +: 3]);
  assign next_afe.temp_single_ended_sel = regs.tout[SFC_POS_SINGLE_ENDED];

  // Registered so the analog switches never see decode glitches
  always_ff @(posedge clk) begin
    if (reset) begin
      afe <= '0;
      afe.temp_excite_current_sel <= SFC_CURR_OFF;
    end else begin
      afe <= next_afe;
    end
  end

endmodule // sfc_afe_decode
`default_nettype wire

// [logic/sfc_config_regs.sv]
// Sensor front-end configuration register bank, top level
`timescale 1ns/1ps
`default_nettype none
module sfc_config_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register access port
  input wire sfc_pkg::sfc_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic addr_miss,
  // Analog control lines
  output var sfc_pkg::sfc_afe_t afe
);
  import sfc_pkg::*;

  // ==========================================================================
  // Address decode
  function automatic logic [7:0] mask_of(input logic [31:0] addr);
    case (addr)
      SFC_ADDR_BRIDGE: mask_of = SFC_MASK_BRIDGE;
      SFC_ADDR_PGAIN: mask_of = SFC_MASK_PGAIN;
      SFC_ADDR_TGAIN: mask_of = SFC_MASK_TGAIN;
      SFC_ADDR_TSRC: mask_of = SFC_MASK_TSRC;
      SFC_ADDR_TOUT: mask_of = SFC_MASK_TOUT;
      default: mask_of = 8'h00;
    endcase
  endfunction

  sfc_regs_t regs;
  sfc_regs_t next_regs;
  wire logic hit_bridge;
  wire logic hit_pgain;
  wire logic hit_tgain;
  wire logic hit_tsrc;
  wire logic hit_tout;
  wire logic hit_any;
  wire logic [7:0] wmasked;
  wire logic [7:0] rsel;

  // One-hot select of the addressed byte
  assign hit_bridge = (req.addr == SFC_ADDR_BRIDGE);
  assign hit_pgain = (req.addr == SFC_ADDR_PGAIN);
  assign hit_tgain = (req.addr == SFC_ADDR_TGAIN);
  assign hit_tsrc = (req.addr == SFC_ADDR_TSRC);
  assign hit_tout = (req.addr == SFC_ADDR_TOUT);
  assign hit_any = hit_bridge | hit_pgain | hit_tgain | hit_tsrc | hit_tout;

  assign wmasked = req.wdata & mask_of(req.addr);

  // ==========================================================================
  // Write path: a write replaces the implemented bits of one byte
  assign next_regs.bridge = (req.wr && hit_bridge) ? wmasked : regs.bridge;
  assign next_regs.pgain = (req.wr && hit_pgain) ? wmasked : regs.pgain;
  assign next_regs.tgain = (req.wr && hit_tgain) ? wmasked : regs.tgain;
  assign next_regs.tsrc = (req.wr && hit_tsrc) ? wmasked : regs.tsrc;
  assign next_regs.tout = (req.wr && hit_tout) ? wmasked : regs.tout;

  // Storage; unmapped writes fall through untouched
  always_ff @(posedge clk) begin
    if (reset) begin
      regs.bridge <= SFC_RST_BRIDGE;
      regs.pgain <= SFC_RST_PGAIN;
      regs.tgain <= SFC_RST_TGAIN;
      regs.tsrc <= SFC_RST_TSRC;
      regs.tout <= SFC_RST_TOUT;
    end else begin
      regs <= next_regs;
    end
  end

  // ==========================================================================
  // Read path
  // unused bits read zero
  assign rsel = ({8{hit_bridge}} & regs.bridge)
              | ({8{hit_pgain}} & regs.pgain)
              | ({8{hit_tgain}} & regs.tgain)
              | ({8{hit_tsrc}} & regs.tsrc)
              | ({8{hit_tout}} & regs.tout);

  // Read data is registered; an unmapped read answers zero and flags a miss
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
      addr_miss <= 1'b0;
    end else begin
      rdata <= req.rd ? rsel : rdata;
      rvalid <= req.rd;
      addr_miss <= (req.rd | req.wr) & ~hit_any;
    end
  end

  // ==========================================================================
  // Analog control decode
  sfc_afe_decode u_decode (
    .clk(clk),
    .reset(reset),
    .regs(regs),
    .afe(afe)
  );

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // Write to the bridge byte reaches the supply enable two edges later
  bridge_enable_a:
    assert property ((req.wr && hit_bridge && !$past(reset))
      |-> ##2 (afe.bridge_supply_on == $past(req.wdata[0], 2)))
    else $error("bridge supply enable does not follow written bit");

  level_decode_a:
    assert property ((regs.bridge[2:1] != 2'h0 && regs.bridge[2:1] != 2'h1)
      |=> afe.bridge_level_sel == SFC_LEVEL_1V25)
    else $error("high level codes must give the lowest level");

  level_low_a:
    assert property ((regs.bridge[2:1] == 2'h1)
      |=> afe.bridge_level_sel == SFC_LEVEL_2V0)
    else $error("level code one must give the middle level");

  pgain_field_a:
    assert property (afe.pressure_gain == $past(regs.pgain[4:0]))
    else $error("pressure gain code does not track its field");

  pflip_field_a:
    assert property ((req.wr && hit_pgain)
      |-> ##2 (afe.pressure_polarity_flip == $past(req.wdata[7], 2)))
    else $error("pressure inversion does not follow written bit");

  tgain_unused_a:
    assert property ((req.wr && hit_tgain)
      |=> (regs.tgain[6:2] == 5'h00) ##1
          (afe.temp_polarity_flip == $past(req.wdata[7], 2)))
    else $error("temperature gain byte keeps unused bits or loses flip");

  tsrc_reserved_a:
    assert property ((regs.tsrc[3:0] != SFC_TSRC_EXT_PINS &&
                      regs.tsrc[3:0] != SFC_TSRC_INTERNAL)
      |=> afe.temp_source == SFC_SRC_RESERVED)
    else $error("reserved source codes must decode as reserved");

  curr_off_a:
    assert property (regs.tsrc[6] |=> afe.temp_excite_current_sel
      == SFC_CURR_OFF)
    else $error("current must be off when the top code bit is set");

  curr_500_a:
    assert property ((regs.tsrc[6:4] == 3'h3)
      |=> afe.temp_excite_current_sel == SFC_CURR_500UA)
    else $error("code three must give the largest current");

  single_ended_a:
    assert property ((req.wr && hit_tout)
      |-> ##2 (afe.temp_single_ended_sel == $past(req.wdata[0], 2)))
    else $error("single-ended select does not follow written bit");

  unused_read_a:
    assert property ((req.rd && hit_any)
      |=> rvalid && ((rdata & ~$past(mask_of(req.addr))) == 8'h00))
    else $error("unused bits must read as zero");

  miss_read_a:
    assert property ((req.rd && !hit_any) |=> rvalid && addr_miss
      && rdata == 8'h00)
    else $error("unmapped read must answer zero and flag a miss");

  // Cleared enable must keep the sensor bridge unpowered
  supply_off_a:
    assert property (!regs.bridge[SFC_POS_BRIDGE_ON]
      |=> !afe.bridge_supply_on)
    else $error("bridge supply must be off while its enable is clear");

  level_top_a:
    assert property ((regs.bridge[2:1] == 2'h0)
      |=> afe.bridge_level_sel == SFC_LEVEL_2V5)
    else $error("level code zero must give the highest level");

  tsrc_ext_a:
    assert property ((regs.tsrc[3:0] == SFC_TSRC_EXT_PINS)
      |=> afe.temp_source == SFC_SRC_EXT_PINS)
    else $error("source code zero must route the external pins");

  tsrc_internal_a:
    assert property ((regs.tsrc[3:0] == SFC_TSRC_INTERNAL)
      |=> afe.temp_source == SFC_SRC_INTERNAL)
    else $error("internal source code must route the internal sensor");

  curr_25_a:
    assert property ((regs.tsrc[6:4] == 3'h0)
      |=> afe.temp_excite_current_sel == SFC_CURR_25UA)
    else $error("code zero must give the smallest current");

  curr_50_a:
    assert property ((regs.tsrc[6:4] == 3'h1)
      |=> afe.temp_excite_current_sel == SFC_CURR_50UA)
    else $error("code one must give the second current step");

  curr_100_a:
    assert property ((regs.tsrc[6:4] == 3'h2)
      |=> afe.temp_excite_current_sel == SFC_CURR_100UA)
    else $error("code two must give the third current step");

  // Stored bytes never hold unused bits, so no unused written bit can reach the analog
  unused_store_a:
    assert property (((regs.bridge & ~SFC_MASK_BRIDGE) == 8'h00)
      && ((regs.pgain & ~SFC_MASK_PGAIN) == 8'h00)
      && ((regs.tgain & ~SFC_MASK_TGAIN) == 8'h00)
      && ((regs.tsrc & ~SFC_MASK_TSRC) == 8'h00)
      && ((regs.tout & ~SFC_MASK_TOUT) == 8'h00))
    else $error("unused register bits must never be stored");

  // Main scenarios
  bridge_on_c: cover property (req.wr && hit_bridge ##2 afe.bridge_supply_on);
  internal_src_c: cover property (afe.temp_source == SFC_SRC_INTERNAL);
  pflip_c: cover property (afe.pressure_polarity_flip);
  miss_c: cover property (addr_miss);
  same_cycle_c: cover property (req.wr && req.rd && hit_any);

endmodule // sfc_config_regs
`default_nettype wire

// [test/tb_top.sv]
// Self-checking testbench of the front-end configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sfc_pkg::*;

  // ==========================================================================
  // Signals and the design under test
  logic clk;
  logic reset;
  sfc_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic addr_miss;
  sfc_afe_t afe;
  int num_errors = 0;
  int checked = 0;

  localparam logic [31:0] ADDRS [5] = '{SFC_ADDR_BRIDGE, SFC_ADDR_PGAIN,
    SFC_ADDR_TGAIN, SFC_ADDR_TSRC, SFC_ADDR_TOUT};
  // Source codes: external, internal and several reserved ones
  localparam logic [3:0] SRCS [8] = '{4'h0, 4'h3, 4'h5, 4'hF, 4'h0, 4'h3,
    4'h8, 4'h1};

  sfc_config_regs i_sfc_config_regs (
    .clk(clk),
    .reset(reset),
    .req(req),
    .rdata(rdata),
    .rvalid(rvalid),
    .addr_miss(addr_miss),
    .afe(afe)
  );

  // Free-running 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================================
  // Shared comparison, bus cycles and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Entered at a falling edge; strobe is held over exactly one rising edge
  task automatic reg_write(input logic [31:0] a, input logic [7:0] d,
                           input logic miss);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
    check(32'(addr_miss), 32'(miss));
    @(negedge clk);
  endtask

  // Read answer stands one cycle, so it is sampled at the next falling edge
  task automatic reg_read(input logic [31:0] a, input logic [7:0] exp,
                          input logic miss);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    check(32'(rvalid), 32'h1);
    check(32'(rdata), 32'(exp));
    check(32'(addr_miss), 32'(miss));
    @(negedge clk);
  endtask

  // Expected control lines worked out from the stored bytes
  task automatic check_afe(input sfc_regs_t m);
    sfc_level_t lvl;
    sfc_tsrc_t src;
    sfc_curr_t cur;
    lvl = (m.bridge[2:1] == 2'b00) ? SFC_LEVEL_2V5 :
          (m.bridge[2:1] == 2'b01) ? SFC_LEVEL_2V0 : SFC_LEVEL_1V25;
    src = (m.tsrc[3:0] == 4'h0) ? SFC_SRC_EXT_PINS :
          (m.tsrc[3:0] == 4'h3) ? SFC_SRC_INTERNAL : SFC_SRC_RESERVED;
    cur = m.tsrc[6] ? SFC_CURR_OFF : sfc_curr_t'({1'b0, m.tsrc[5:4]});
    check(32'(afe.bridge_supply_on), 32'(m.bridge[0]));
    check(32'(afe.bridge_level_sel), 32'(lvl));
    check(32'(afe.pressure_gain), 32'(m.pgain[4:0]));
    check(32'(afe.pressure_polarity_flip), 32'(m.pgain[7]));
    check(32'({afe.temp_polarity_flip, afe.temp_gain}),
          32'({m.tgain[7], m.tgain[1:0]}));
    check(32'(afe.temp_source), 32'(src));
    check(32'(afe.temp_excite_current_sel), 32'(cur));
    check(32'(afe.temp_single_ended_sel), 32'(m.tout[0]));
  endtask

  task automatic verify_all(input sfc_regs_t v);
    sfc_regs_t m;
    m = v & {SFC_MASK_BRIDGE, SFC_MASK_PGAIN, SFC_MASK_TGAIN, SFC_MASK_TSRC,
             SFC_MASK_TOUT};
    check_afe(m);
    for (int i = 0; i < 5; i++) begin
      reg_read(ADDRS[i], m[39-8*i -: 8], 1'b0);
    end
  endtask

  // Writes one idle cycle apart, then the two-edge wait before the controls settle
  task automatic write_all(input sfc_regs_t v);
    for (int i = 0; i < 5; i++) begin
      reg_write(ADDRS[i], v[39-8*i -: 8], 1'b0);
    end
    repeat (2) @(negedge clk);
    verify_all(v);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    verify_all({8'h00, 8'h00, 8'h00, 8'h40, 8'h00});
    $display("test_reset done");
  endtask

  // Every level, current and gain corner with unused bits written as ones
  task automatic test_fields();
    logic [2:0] k3;
    for (int k = 0; k < 8; k++) begin
      k3 = k[2:0];
      write_all({5'h1F, k3, k3[0], 2'b11, k3, k3[1:0], k3[1], 5'h1F,
                 k3[1:0], 1'b1, k3, SRCS[k], 7'h7F, k3[0]});
    end
    write_all({8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF});
    write_all({8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    $display("test_fields done");
  endtask

  // Read and write together return the old byte, then the new one
  task automatic test_same_cycle();
    req.wr = 1'b1;
    req.rd = 1'b1;
    req.addr = SFC_ADDR_PGAIN;
    req.wdata = 8'hE5;
    @(negedge clk);
    req.wr = 1'b0;
    req.rd = 1'b0;
    check(32'(rdata), 32'h0);
    @(negedge clk);
    reg_read(SFC_ADDR_PGAIN, 8'h85, 1'b0);
    $display("test_same_cycle done");
  endtask

  // Unmapped places are flagged, read as zero and change nothing
  task automatic test_unmapped();
    reg_write(32'h40000038, 8'hFF, 1'b1);
    reg_write(32'h40000033, 8'hFF, 1'b1);
    reg_read(32'h40000039, 8'h00, 1'b1);
    reg_read(32'h4000003B, 8'h00, 1'b1);
    verify_all({8'h00, 8'h85, 8'h00, 8'h00, 8'h00});
    $display("test_unmapped done");
  endtask

  // ==========================================================================
  // Main sequence: reset for three cycles, then the scenarios
  initial begin
    reset = 1'b1;
    req = '0;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    test_reset();
    test_fields();
    test_same_cycle();
    test_unmapped();
    stop_test();
  end

  // Watchdog: the run needs well under a thousand cycles
  initial begin
    #200000;
    num_errors++;
    $display("Watchdog expired at t=%0t", $time);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
